/* File: hdl/capture_compare_unit.sv */
`timescale 1ns/1ps
// What this block does
// R1 - up to sixteen channels, one-cycle resolution, eight cycles staggered
// R2 - two independent 16-bit timers, each with a reload register
// R3 - timer clock from prescaled system clock or external timer overflow
// R4 - timers can also count external count input events
// R5 - sixteen channel registers, each on either timer, capture or compare
// R6 - each channel owns a pin: capture input or compare output
// R7 - capture latches the assigned timer and raises the channel interrupt
// R8 - capture edge per channel: rising, falling or either
// R9 - compare channels check their timer after each timer step and act on equality
// R10 - mode 0: interrupt on every match, pin untouched
// R11 - mode 1: every match toggles the pin
// R12 - mode 2: interrupt only, at most once per timer period
// R13 - mode 3: match sets pin, timer overflow clears it, once per period
// R14 - double register: two channels toggle one shared pin
// R15 - single event option stops compare output after one edge or pulse
// R16 - on overflow a timer reloads from its reload register
module capture_compare_unit
   import capture_compare_pkg::*;
#(
   parameter int N_CH = 16
)
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // register port
   input wire reg_req_s req_i,
   output logic [DATA_W-1:0] rdata_o,
   // timer clock sources
   input wire logic ext_timer_overflow_i,
   input wire logic [NUM_TMR-1:0] count_in_i,
   // channel pins
   input wire logic [N_CH-1:0] cc_pin_i,
   output logic [N_CH-1:0] cc_pin_o,
   output logic [N_CH-1:0] cc_oe_n_o,
   // interrupt
   output logic irq_o
);

   localparam int HALF = N_CH / 2;

   generate
      if (N_CH < 2 || N_CH > 16 || (N_CH % 2) != 0)
      begin : g_bad
         $error("N_CH must be even and between 2 and 16");
      end
   endgenerate

   typedef struct packed {
      logic [DATA_W-1:0] rdata;
      logic [2:0] ctrl;
      logic [NUM_TMR-1:0][4:0] tcfg;
      logic [NUM_TMR-1:0][TMR_W-1:0] tcnt;
      logic [NUM_TMR-1:0][TMR_W-1:0] trel;
      logic [NUM_TMR-1:0] step;
      logic [NUM_TMR-1:0] ovf;
      logic [PRESC_W-1:0] presc;
      logic [2:0] slot;
      logic [N_CH-1:0][7:0] cfg;
      logic [N_CH-1:0][TMR_W-1:0] val;
      logic [N_CH-1:0] fired;
      logic [N_CH-1:0] spent;
      logic [N_CH-1:0] pin;
      logic [N_CH-1:0] oe_n;
      logic [N_CH-1:0] p1;
      logic [N_CH-1:0] p2;
      logic [N_CH-1:0] p3;
      logic [N_CH-1:0] plvl;
      logic [NUM_TMR-1:0] c1;
      logic [NUM_TMR-1:0] c2;
      logic [NUM_TMR-1:0] c3;
      logic [NUM_TMR-1:0] clvl;
      logic [STAT_W-1:0] stat;
      logic [STAT_W-1:0] mask;
      logic irq;
   } state_s;

   state_s st_r;
   state_s st_nxt;

   // channel register decode: valid bit and channel index
   function automatic logic [4:0] chan_dec(input logic [ADDR_W-1:0] a,
                                           input logic [ADDR_W-1:0] base);
      logic [4:0] r;
      r = '0;
      if (a[7:6] == base[7:6] && a[1:0] == 2'h0
          && 32'(a[5:2]) < N_CH)
      begin
         r = {1'b1, a[5:2]};
      end
      return r;
   endfunction

   // outputs straight from the state register
   assign rdata_o = st_r.rdata;
   assign cc_pin_o = st_r.pin;
   assign cc_oe_n_o = st_r.oe_n;
   assign irq_o = st_r.irq;

   // next state of the whole unit
   always_comb
   begin
      logic [4:0] cd;
      logic [4:0] vd;
      logic [NUM_TMR-1:0] tick;
      logic [NUM_TMR-1:0] cnt_rise;
      logic [N_CH-1:0] rise;
      logic [N_CH-1:0] fall;
      logic [N_CH-1:0] hit;
      logic [N_CH-1:0] ev;
      logic [PRESC_W:0] pmask;
      logic stag_ok;
      ch_cfg_s cf;
      tmr_cfg_s tc;
      logic [TMR_W-1:0] tv;
      logic per;
      logic [NUM_TMR-1:0] sw_wr;
      cd = chan_dec(req_i.addr, OFS_CHCFG);
      vd = chan_dec(req_i.addr, OFS_CHVAL);
      tick = '0;
      cnt_rise = '0;
      rise = '0;
      fall = '0;
      hit = '0;
      ev = '0;
      pmask = '0;
      cf = CH_CFG_RST;
      tc = TMR_CFG_RST;
      tv = '0;
      per = 1'b0;
      stag_ok = 1'b0;
      sw_wr = '0;
      st_nxt = st_r;
      st_nxt.rdata = '0;

      // free running prescaler and stagger slot
      st_nxt.presc = st_r.presc + 1'b1;
      st_nxt.slot = st_r.slot + 1'b1;
      stag_ok = !st_r.ctrl[CTRL_STAG] || st_r.slot == STAG_LAST; // R1

      // pin synchronisers: a change counts when stages two and three agree
      st_nxt.p1 = cc_pin_i;
      st_nxt.p2 = st_r.p1;
      st_nxt.p3 = st_r.p2;
      st_nxt.c1 = count_in_i;
      st_nxt.c2 = st_r.c1;
      st_nxt.c3 = st_r.c2;
      for (int i = 0; i < N_CH; i++)
      begin
         if (st_r.p2[i] == st_r.p3[i] && st_r.p3[i] != st_r.plvl[i])
         begin
            st_nxt.plvl[i] = st_r.p3[i];
            rise[i] = st_r.p3[i];
            fall[i] = !st_r.p3[i];
         end
      end
      for (int t = 0; t < NUM_TMR; t++)
      begin
         if (st_r.c2[t] == st_r.c3[t] && st_r.c3[t] != st_r.clvl[t])
         begin
            st_nxt.clvl[t] = st_r.c3[t];
            cnt_rise[t] = st_r.c3[t];
         end
      end

      // register writes
      if (req_i.wr)
      begin
         if (req_i.addr == OFS_CTRL)
            st_nxt.ctrl = req_i.wdata[2:0];
         else if (req_i.addr == OFS_TCFG0)
            st_nxt.tcfg[0] = req_i.wdata[4:0];
         else if (req_i.addr == OFS_TCFG1)
            st_nxt.tcfg[1] = req_i.wdata[4:0];
         else if (req_i.addr == OFS_TCNT0)
            st_nxt.tcnt[0] = req_i.wdata[TMR_W-1:0];
         else if (req_i.addr == OFS_TCNT1)
            st_nxt.tcnt[1] = req_i.wdata[TMR_W-1:0];
         else if (req_i.addr == OFS_TREL0)
            st_nxt.trel[0] = req_i.wdata[TMR_W-1:0];
         else if (req_i.addr == OFS_TREL1)
            st_nxt.trel[1] = req_i.wdata[TMR_W-1:0];
         else if (req_i.addr == OFS_MASK)
            st_nxt.mask = req_i.wdata[STAT_W-1:0];
         else if (cd[4])
         begin
            st_nxt.cfg[cd[3:0]] = req_i.wdata[7:0];
            st_nxt.spent[cd[3:0]] = 1'b0; // rearm single event
            st_nxt.fired[cd[3:0]] = 1'b0;
         end
         else if (vd[4])
            st_nxt.val[vd[3:0]] = req_i.wdata[TMR_W-1:0];
      end

      // register reads, data stand in the following cycle
      if (req_i.rd)
      begin
         if (req_i.addr == OFS_CTRL)
            st_nxt.rdata = DATA_W'(st_r.ctrl);
         else if (req_i.addr == OFS_TCFG0)
            st_nxt.rdata = DATA_W'(st_r.tcfg[0]);
         else if (req_i.addr == OFS_TCFG1)
            st_nxt.rdata = DATA_W'(st_r.tcfg[1]);
         else if (req_i.addr == OFS_TCNT0)
            st_nxt.rdata = DATA_W'(st_r.tcnt[0]);
         else if (req_i.addr == OFS_TCNT1)
            st_nxt.rdata = DATA_W'(st_r.tcnt[1]);
         else if (req_i.addr == OFS_TREL0)
            st_nxt.rdata = DATA_W'(st_r.trel[0]);
         else if (req_i.addr == OFS_TREL1)
            st_nxt.rdata = DATA_W'(st_r.trel[1]);
         else if (req_i.addr == OFS_STAT)
         begin
            st_nxt.rdata = DATA_W'(st_r.stat);
            st_nxt.stat = '0; // read clears, later sets win
         end
         else if (req_i.addr == OFS_MASK)
            st_nxt.rdata = DATA_W'(st_r.mask);
         else if (cd[4])
            st_nxt.rdata = DATA_W'(st_r.cfg[cd[3:0]]);
         else if (vd[4])
            st_nxt.rdata = DATA_W'(st_r.val[vd[3:0]]);
      end

      // timers: clock source select, count up, reload on overflow
      for (int t = 0; t < NUM_TMR; t++)
      begin
         tc = tmr_cfg_s'(st_r.tcfg[t]);
         pmask = (PRESC_W+1)'((8'h1 << tc.presc) - 8'h1);
         case (tc.src)
            SRC_PRESCALE:
               tick[t] = (st_r.presc & pmask[PRESC_W-1:0])
                         == pmask[PRESC_W-1:0]; // R3
            SRC_EXT_OVF:
               tick[t] = ext_timer_overflow_i; // R3
            SRC_COUNT_IN:
               tick[t] = cnt_rise[t]; // R4
            default:
               tick[t] = 1'b0;
         endcase
         // a software write of the count wins over this cycle's step,
         // so a running timer can be moved without losing the new value
         sw_wr[t] = req_i.wr
                    && req_i.addr == (t == 0 ? OFS_TCNT0 : OFS_TCNT1);
         tick[t] = tick[t] && st_r.ctrl[CTRL_RUN0 + t] && stag_ok
                   && !sw_wr[t]; // R1
         st_nxt.step[t] = tick[t];
         st_nxt.ovf[t] = tick[t] && st_r.tcnt[t] == TMR_FULL;
         if (tick[t])
         begin
            if (st_r.tcnt[t] == TMR_FULL)
               st_nxt.tcnt[t] = st_r.trel[t]; // R16
            else
               st_nxt.tcnt[t] = st_r.tcnt[t] + 1'b1; // R2
         end
         if (st_nxt.ovf[t])
            st_nxt.stat[STAT_TOVF0 + t] = 1'b1;
      end

      // compare hits: timer just stepped onto the channel value
      for (int c = 0; c < N_CH; c++)
      begin
         cf = ch_cfg_s'(st_r.cfg[c]);
         hit[c] = cf.mode[2] && !st_r.spent[c]
                  && st_r.step[cf.tsel]
                  && st_r.tcnt[cf.tsel] == st_r.val[c]; // R9
      end

      // channel actions
      for (int c = 0; c < N_CH; c++)
      begin
         cf = ch_cfg_s'(st_r.cfg[c]);
         tv = st_r.tcnt[cf.tsel];
         per = st_r.ovf[cf.tsel];
         if (per)
            st_nxt.fired[c] = 1'b0;
         case (cf.mode)
            CH_CAPTURE:
            begin
               if ((rise[c] && cf.edge_sel[0])
                   || (fall[c] && cf.edge_sel[1])) // R8
               begin
                  st_nxt.val[c] = tv; // R7
                  ev[c] = 1'b1; // R7
               end
            end
            CH_CMP0:
            begin
               if (hit[c])
               begin
                  ev[c] = 1'b1; // R10
                  st_nxt.spent[c] = cf.single; // R15
               end
            end
            CH_CMP1:
            begin
               if (hit[c])
               begin
                  st_nxt.pin[c] = !st_r.pin[c]; // R11
                  ev[c] = 1'b1;
                  st_nxt.spent[c] = cf.single; // R15
               end
            end
            CH_CMP2:
            begin
               if (hit[c] && (!st_r.fired[c] || per))
               begin
                  ev[c] = 1'b1; // R12
                  st_nxt.fired[c] = 1'b1; // R12
                  st_nxt.spent[c] = cf.single; // R15
               end
            end
            CH_CMP3:
            begin
               if (per && st_r.pin[c])
               begin
                  st_nxt.pin[c] = 1'b0; // R13
                  st_nxt.spent[c] = cf.single; // R15
               end
               if (hit[c] && (!st_r.fired[c] || per))
               begin
                  st_nxt.pin[c] = 1'b1; // R13
                  st_nxt.fired[c] = 1'b1; // R13
                  ev[c] = 1'b1;
               end
            end
            default:
            begin
            end
         endcase
         // pin direction: driven only by output modes
         st_nxt.oe_n[c] = !(cf.mode == CH_CMP1 || cf.mode == CH_CMP3); // R6
      end

      // double register: the upper partner toggles the lower pin too
      for (int c = 0; c < HALF; c++)
      begin
         cf = ch_cfg_s'(st_r.cfg[c]);
         if (cf.dbl)
         begin
            st_nxt.oe_n[c] = 1'b0; // R14
            st_nxt.oe_n[c + HALF] = 1'b1; // R14
            // the partner pin is released, so it keeps its last level
            st_nxt.pin[c + HALF] = st_r.pin[c + HALF]; // R14
            if (hit[c] ^ hit[c + HALF])
               st_nxt.pin[c] = !st_r.pin[c]; // R14
            else
               st_nxt.pin[c] = st_r.pin[c];
            if (hit[c + HALF])
               ev[c + HALF] = 1'b1;
            if (hit[c])
               ev[c] = 1'b1;
         end
      end

      // sticky status, set wins over the read clear
      st_nxt.stat[N_CH-1:0] = st_nxt.stat[N_CH-1:0] | ev; // R5
      st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
   end

   // single state register
   always_ff @(posedge core_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         st_r <= '0;
         st_r.oe_n <= '1;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

endmodule

/* File: pkg/capture_compare_pkg.sv */
package capture_compare_pkg;

   // bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int TMR_W = 16;
   localparam int NUM_TMR = 2;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TCFG0 = 8'h04;
   localparam logic [7:0] OFS_TCFG1 = 8'h08;
   localparam logic [7:0] OFS_TCNT0 = 8'h0c;
   localparam logic [7:0] OFS_TCNT1 = 8'h10;
   localparam logic [7:0] OFS_TREL0 = 8'h14;
   localparam logic [7:0] OFS_TREL1 = 8'h18;
   localparam logic [7:0] OFS_STAT = 8'h1c;
   localparam logic [7:0] OFS_MASK = 8'h20;
   localparam logic [7:0] OFS_CHCFG = 8'h40;
   localparam logic [7:0] OFS_CHVAL = 8'h80;

   // control register bit positions
   localparam int CTRL_RUN0 = 0;
   localparam int CTRL_RUN1 = 1;
   localparam int CTRL_STAG = 2;

   // status bit of a timer overflow, above the channel bits
   localparam int STAT_TOVF0 = 16;
   localparam int STAT_W = 18;

   // staggered operation: one timer step every eight cycles
   localparam int STAG_SLOTS = 8;
   localparam logic [2:0] STAG_LAST = 3'h7;

   // prescaler counter width, dividers 1 to 128
   localparam int PRESC_W = 7;

   // timer reset value and full count
   localparam logic [15:0] TMR_RST = 16'h0000;
   localparam logic [15:0] TMR_FULL = 16'hffff;

   typedef enum logic [1:0] {
      SRC_PRESCALE = 2'h0,
      SRC_EXT_OVF = 2'h1,
      SRC_COUNT_IN = 2'h3
   } clk_src_e;

   typedef enum logic [2:0] {
      CH_OFF = 3'h0,
      CH_CAPTURE = 3'h1,
      CH_CMP0 = 3'h4,
      CH_CMP1 = 3'h5,
      CH_CMP2 = 3'h6,
      CH_CMP3 = 3'h7
   } ch_mode_e;

   // channel config: bits 2:0 mode, 4:3 edge, 5 timer, 6 single, 7 double
   typedef struct packed {
      logic dbl;
      logic single;
      logic tsel;
      logic [1:0] edge_sel;
      ch_mode_e mode;
   } ch_cfg_s;

   // timer config: bits 1:0 source, 4:2 prescale exponent
   typedef struct packed {
      logic [2:0] presc;
      clk_src_e src;
   } tmr_cfg_s;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } reg_req_s;

   localparam ch_cfg_s CH_CFG_RST = '{1'b0, 1'b0, 1'b0, 2'h0, CH_OFF};
   localparam tmr_cfg_s TMR_CFG_RST = '{3'h0, SRC_PRESCALE};

endpackage

/* File: test/capture_compare_unit_bench.sv */
`timescale 1ns/1ps
module capture_compare_unit_bench
   import capture_compare_pkg::*;
;
   logic core_clk_i;
   logic sys_rst_i;
   reg_req_s req;
   logic [31:0] rdata;
   logic ovf;
   logic [1:0] cnt;
   logic [15:0] pin_i;
   logic [15:0] pin_o;
   logic [15:0] oe_n;
   logic [15:0] drv;
   logic irq;
   logic [31:0] v;
   int mismatches;
   int n_checks;
   int chs[5] = '{1, 2, 3, 4, 8};
   logic [7:0] cfgs[5] = '{8'h04, 8'h06, 8'h07, 8'h05, 8'h45};

   // unit and the circuit on its pins
   capture_compare_unit #(.N_CH(16)) capture_compare_unit_inst (
      .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .req_i(req),
      .rdata_o(rdata), .ext_timer_overflow_i(ovf), .count_in_i(cnt),
      .cc_pin_i(pin_i), .cc_pin_o(pin_o), .cc_oe_n_o(oe_n), .irq_o(irq));
   cc_pin_model #(.N_CH(16), .SLOW(1'b1)) cc_pin_model_inst (
      .core_clk_i(core_clk_i), .cc_pin_o(pin_o), .cc_oe_n_o(oe_n),
      .cc_pin_i(pin_i), .drv_lvl_i(drv));

   // clock
   initial
   begin
      core_clk_i = 1'b0;
      forever #2.5 core_clk_i = ~core_clk_i;
   end

   // verdict and end of run
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
      begin
         $display("Testbench passed");
      end
      else
      begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // compare one value
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         mismatches++;
      end
   endtask

   // bus write and read
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i) req <= '{1'b1, 1'b0, a, d};
      @(posedge core_clk_i) req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk_i) req <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge core_clk_i) req <= '0;
      #1 d = rdata;
   endtask
   task automatic rc(input string nm, input logic [7:0] a,
      input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      chk(nm, e, d & m);
   endtask

   // bounded wait for the interrupt
   task automatic await_irq();
      int k;
      k = 0;
      while (irq !== 1'b1 && k < 40)
      begin
         @(posedge core_clk_i);
         #1 k++;
      end
      if (irq !== 1'b1)
      begin
         chk("irq wait", 32'h1, {31'h0, irq});
         finish_test();
      end
   endtask

   // main sequence
   initial
   begin
      mismatches = 0;
      n_checks = 0;
      sys_rst_i = 1'b1;
      req = '0;
      ovf = 1'b0;
      cnt = 2'h0;
      drv = 16'h0;
      repeat (6) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge core_clk_i);
      #1 chk("oe_n", 32'h0000ffff, {16'h0, oe_n});
      chk("pins", 32'h0, {15'h0, irq, pin_o});
      // back to back write and read, unmapped place, mask
      @(posedge core_clk_i) req <= '{1'b1, 1'b0, OFS_TREL0, 32'hffffffe0};
      @(posedge core_clk_i) req <= '{1'b0, 1'b1, OFS_TREL0, 32'h0};
      @(posedge core_clk_i) req <= '0;
      #1 chk("reload", 32'h0000ffe0, rdata);
      wr(8'h24, 32'hffffffff);
      rc("unmapped", 8'h24, '1, 32'h0);
      wr(OFS_MASK, 32'h2);
      rc("mask", OFS_MASK, '1, 32'h2);
      // external overflow and count input as timer clocks
      wr(OFS_TCFG0, 32'h1);
      wr(OFS_TCFG1, 32'h3);
      wr(OFS_CTRL, 32'h3);
      for (int i = 0; i < 5; i++)
      begin
         @(posedge core_clk_i) ovf <= 1'b1;
         cnt <= 2'h2;
         @(posedge core_clk_i) ovf <= 1'b0;
         repeat (6) @(posedge core_clk_i);
         cnt <= 2'h0;
         repeat (6) @(posedge core_clk_i);
      end
      wr(OFS_CTRL, 32'h0);
      rc("ext ticks", OFS_TCNT0, '1, 32'h5);
      rc("count ticks", OFS_TCNT1, '1, 32'h5);
      // capture on rising, falling and both edges, timer 1 held
      rd(OFS_STAT, v);
      for (int c = 5; c < 8; c++)
      begin
         wr(8'(OFS_CHCFG + 4 * c), 32'(8 * c + 1));
      end
      @(posedge core_clk_i) drv <= 16'h00e0;
      repeat (10) @(posedge core_clk_i);
      wr(OFS_TCNT1, 32'h7);
      @(posedge core_clk_i) drv <= 16'h0;
      repeat (10) @(posedge core_clk_i);
      rc("cap rise", 8'(OFS_CHVAL + 20), '1, 32'h5);
      rc("cap fall", 8'(OFS_CHVAL + 24), '1, 32'h7);
      rc("cap both", 8'(OFS_CHVAL + 28), '1, 32'h7);
      rc("cap status", OFS_STAT, 32'hffff, 32'h00e0);
      // compare modes on timer 0, passed twice in one period
      wr(OFS_TCFG0, 32'h0);
      for (int i = 0; i < 5; i++)
      begin
         wr(8'(OFS_CHCFG + 4 * chs[i]), {24'h0, cfgs[i]});
         wr(8'(OFS_CHVAL + 4 * chs[i]), 32'h0000fff4);
      end
      wr(OFS_TCNT0, 32'h0000ffe8);
      #1 chk("oe_n cmp", 32'h0000fee7, {16'h0, oe_n});
      wr(OFS_CTRL, 32'h1);
      await_irq();
      chk("pins 1", 32'h0118, {16'h0, pin_o & 16'h011e});
      rc("hits 1", OFS_STAT, 32'h116, 32'h116);
      wr(OFS_TCNT0, 32'h0000ffe8);
      repeat (16) @(posedge core_clk_i);
      #1 chk("pins 2", 32'h0108, {16'h0, pin_o & 16'h011e});
      rc("hits 2", OFS_STAT, 32'h116, 32'h12);
      repeat (8) @(posedge core_clk_i);
      #1 chk("pins 3", 32'h0100, {16'h0, pin_o & 16'h011e});
      rc("overflow", OFS_STAT, 32'h10000, 32'h10000);
      chk("irq masked", 32'h0, {31'h0, irq});
      repeat (22) @(posedge core_clk_i);
      #1 chk("pins 4", 32'h0118, {16'h0, pin_o & 16'h011e});
      rc("hits 3", OFS_STAT, 32'h116, 32'h16);
      // staggered operation: one step every eight cycles
      wr(OFS_CTRL, 32'h0);
      wr(OFS_TCNT0, 32'h0);
      wr(OFS_CTRL, 32'h5);
      repeat (80) @(posedge core_clk_i);
      wr(OFS_CTRL, 32'h0);
      rd(OFS_TCNT0, v);
      chk("stagger", 32'h1, {31'h0, v >= 32'h9 && v <= 32'hb});
      // prescaled clock: timer 1 divided by four
      wr(OFS_TCFG1, 32'h8);
      wr(OFS_TCNT1, 32'h0);
      wr(OFS_CTRL, 32'h2);
      repeat (80) @(posedge core_clk_i);
      wr(OFS_CTRL, 32'h0);
      rd(OFS_TCNT1, v);
      chk("prescale", 32'h1, {31'h0, v >= 32'h14 && v <= 32'h15});
      // double register: channels 0 and 8 toggle pin 0 together
      wr(OFS_CHCFG, 32'h85);
      wr(OFS_CHVAL, 32'h10);
      wr(8'(OFS_CHCFG + 32), 32'h5);
      wr(8'(OFS_CHVAL + 32), 32'h20);
      wr(OFS_TCNT0, 32'h0);
      wr(OFS_CTRL, 32'h1);
      repeat (24) @(posedge core_clk_i);
      #1 chk("dbl pin 1", 32'h0101, {16'h0, pin_o & 16'h0101});
      chk("dbl oe_n", 32'h0100, {16'h0, oe_n & 16'h0101});
      repeat (16) @(posedge core_clk_i);
      #1 chk("dbl pin 2", 32'h0100, {16'h0, pin_o & 16'h0101});
      rc("dbl hits", OFS_STAT, 32'h101, 32'h101);
      finish_test();
   end
endmodule

/* File: test/capture_compare_unit_chk.sv */
`timescale 1ns/1ps
module capture_compare_unit_chk
   import capture_compare_pkg::*;
#(
   parameter int N_CH = 16
)
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // register port
   input wire reg_req_s req_i,
   input wire logic [DATA_W-1:0] rdata_o,
   // timer sources and pins
   input wire logic ext_timer_overflow_i,
   input wire logic [NUM_TMR-1:0] count_in_i,
   input wire logic [N_CH-1:0] cc_pin_i,
   input wire logic [N_CH-1:0] cc_pin_o,
   input wire logic [N_CH-1:0] cc_oe_n_o,
   input wire logic irq_o
);
   logic [STAT_W-1:0] mask_r;
   logic [STAT_W-1:0] mask_nxt;

   // shadow of the interrupt mask as written over the bus
   always_comb
   begin
      mask_nxt = mask_r;
      if (req_i.wr && req_i.addr == OFS_MASK)
      begin
         mask_nxt = req_i.wdata[STAT_W-1:0];
      end
   end

   // shadow register
   always_ff @(posedge core_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         mask_r <= '0;
      end
      else
      begin
         mask_r <= mask_nxt;
      end
   end

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   // bus and pin relations
   rdata_idle_a:
   assert property (!$past(req_i.rd) |-> rdata_o == '0)
      else $error("read data not zero outside a read answer");
   reset_pins_a:
   assert property ($past(sys_rst_i) |-> cc_oe_n_o == '1 && cc_pin_o == '0
      && !irq_o) else $error("outputs not idle after reset");
   unmapped_read_a:
   assert property (req_i.rd && req_i.addr == 8'h24 |=> rdata_o == '0)
      else $error("unmapped read returned data");
   reload_back_a:
   assert property (req_i.wr && req_i.addr == OFS_TREL0 ##1 req_i.rd
      && req_i.addr == OFS_TREL0 |=> rdata_o == {16'h0000,
      $past(req_i.wdata[15:0], 2)}) else $error("reload readback wrong");
   mask_back_a:
   assert property (req_i.rd && req_i.addr == OFS_MASK |=>
      rdata_o == DATA_W'(mask_r)) else $error("mask readback wrong");
   irq_mask_a:
   assert property (mask_r == '0 && $past(mask_r) == '0 |-> !irq_o)
      else $error("interrupt with everything masked");
   irq_status_a:
   assert property (req_i.rd && req_i.addr == OFS_STAT ##1
      (|(rdata_o[STAT_W-1:0] & mask_r)) |-> irq_o || $past(irq_o))
      else $error("masked status set but no interrupt");
   pin_drive_a:
   assert property (((cc_pin_o ^ $past(cc_pin_o)) & cc_oe_n_o
      & $past(cc_oe_n_o)) == '0) else $error("undriven pin changed");
endmodule

bind capture_compare_unit capture_compare_unit_chk #(.N_CH(N_CH))
   capture_compare_unit_chk_inst (.core_clk_i(core_clk_i),
   .sys_rst_i(sys_rst_i), .req_i(req_i), .rdata_o(rdata_o),
   .ext_timer_overflow_i(ext_timer_overflow_i), .count_in_i(count_in_i),
   .cc_pin_i(cc_pin_i), .cc_pin_o(cc_pin_o), .cc_oe_n_o(cc_oe_n_o),
   .irq_o(irq_o));

/* File: test/cc_pin_model.sv */
`timescale 1ns/1ps
module cc_pin_model
#(
   parameter int N_CH = 16,
   parameter bit SLOW = 1'b0
)
(
   // clock
   input wire logic core_clk_i,
   // unit side of the pins
   input wire logic [N_CH-1:0] cc_pin_o,
   input wire logic [N_CH-1:0] cc_oe_n_o,
   output logic [N_CH-1:0] cc_pin_i,
   // levels the outside circuit puts on its pins
   input wire logic [N_CH-1:0] drv_lvl_i
);
   logic [N_CH-1:0] lvl_r;

   // a slow circuit shows its level one cycle late
   always_ff @(posedge core_clk_i)
   begin
      lvl_r <= drv_lvl_i;
   end

   // wire level: the unit wins where it drives
   assign cc_pin_i = (cc_pin_o & ~cc_oe_n_o)
      | ((SLOW ? lvl_r : drv_lvl_i) & cc_oe_n_o);
endmodule
